/* verilog/raed_defs.svh */
// Constants of the reset and exception dispatch unit: event codes,
// vector offsets, status word fields and reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef RAED_DEFS_SVH
`define RAED_DEFS_SVH

`define RAED_CODE_POWER_ON 12'h000
`define RAED_CODE_MANUAL 12'h020
`define RAED_CODE_DEBUG 12'h000
`define RAED_CODE_TLB_RD 12'h040
`define RAED_CODE_TLB_WR 12'h060
`define RAED_CODE_LOOP 12'h070
`define RAED_CODE_INIT_WR 12'h080
`define RAED_CODE_PROT_RD 12'h0A0
`define RAED_CODE_PROT_WR 12'h0C0
`define RAED_CODE_ADDR_RD 12'h0E0
`define RAED_CODE_ADDR_WR 12'h100
`define RAED_CODE_TRAP 12'h160
`define RAED_CODE_RESV 12'h180
`define RAED_CODE_SLOT 12'h1A0
`define RAED_CODE_BREAK 12'h1E0
`define RAED_CODE_DMA 12'h5C0

`define RAED_RESET_PC 32'hA0000000
`define RAED_VEC_MISS 32'h00000400
`define RAED_VEC_GEN 32'h00000100
`define RAED_USER_LIMIT 32'h80000000
`define RAED_VECTOR_BASE_RESET 32'h00000000

`define RAED_SW_PRIV 30
`define RAED_SW_BANK 29
`define RAED_SW_HOLD 28
`define RAED_SW_DSP 12
`define RAED_SW_MASK_HI 7
`define RAED_SW_MASK_LO 4
`define RAED_MASK_RESET 4'hF
`define RAED_SW_RESET 32'h700000F0
`define RAED_SW_MODE_SET 32'h70000000

`define RAED_PAGE_VPN_LO 10
`define RAED_PAGE_ID_HI 7
`define RAED_WAY_HI 7
`define RAED_WAY_LO 6
`define RAED_TRAP_HI 9

`define RAED_SIZE_BYTE 2'h0
`define RAED_SIZE_WORD 2'h1
`define RAED_SIZE_LONG 2'h2

`endif

/* verilog/raed_pkg.sv */
// Types and shared decoding of the reset and exception dispatch unit.
// Assumes raed_defs.svh is on the include path.
`include "raed_defs.svh"

package raed_pkg;

    typedef enum logic [3:0] {
        RAED_EV_NONE = 4'h1,
        RAED_EV_RESET = 4'h2,
        RAED_EV_DOUBLE = 4'h4,
        RAED_EV_GENERAL = 4'h8
    } raed_event_e;

    // Alignment fault for a data access of the given size
    function automatic logic raed_misaligned(input logic [1:0] low, input logic [1:0] size);
        logic bad;
        bad = 1'b0;
        if (size == `RAED_SIZE_WORD) begin
            bad = low[0];
        end else if (size == `RAED_SIZE_LONG) begin
            bad = |low;
        end
        return bad;
    endfunction

endpackage

/* verilog/raed_access_check.sv */
// Address error and page protection check for one CPU memory access.
// Assumes the access fields are stable in the cycle they are presented.
`timescale 1ns/1ns
`include "raed_defs.svh"

module raed_access_check (
    // Access
    input wire logic [31:0] addr,
    input wire logic [1:0] size,
    input wire logic fetch,
    input wire logic write,
    input wire logic user,
    // Page protection
    input wire logic [1:0] rights,
    // Results
    output logic addr_fault,
    output logic rights_fault
);
    logic align_bad;
    logic space_bad;

    // Fetches must be even; data uses the shared size check
    assign align_bad = fetch ? addr[0] : raed_pkg::raed_misaligned(addr[1:0], size);
    assign space_bad = user && (addr >= `RAED_USER_LIMIT);
    assign addr_fault = align_bad || space_bad;

    // Privileged: read always, write needs bit 0; user: 10 read, 11 both
    always_comb begin
        if (user) begin
            rights_fault = !rights[1] || (write && !rights[0]);
        end else begin
            rights_fault = write && !rights[0];
        end
    end
endmodule

/* verilog/raed_top.sv */
// Reset and exception dispatch: takes reset sources and fault reports,
// records the event, saves context and redirects instruction fetch.
// Assumes at most one decoded instruction and one access per cycle, all
// inputs synchronous to MCLK, and the pipeline holding fetch on redirect.
// Notes on behaviour
// - Power-on pin low writes code 000, inits base and status, fetches A0000000.
// - Manual pin low writes code 020, inits base and status, branches to reset.
// - Any reset clears base, sets the three mode flags, mask all ones.
// - Debug reset command runs the power-on sequence with code 000.
// - TLB faults record faulting address, page number and space id.
// - A TLB miss advances the replacement way by one.
// - TLB miss writes 040 read or 060 write, vectors to base plus 400.
// - Invalid entry records its way, miss codes, vectors to base plus 100.
// - TLB or address fault at loop end, other than store to clean page, writes 070, saves next address.
// - Store to clean page records way, writes 080, general vector.
// - Two-bit rights code gates reads and writes by privilege.
// - Protection violation writes 0A0 read or 0C0 write, general vector.
// - Odd fetch, misaligned word or long, or user high space is an address error.
// - Address error records faulting address, writes 0E0 read or 100 write.
// - Trap saves next address, immediate times four, writes 160.
// - Undefined, user privileged or disabled DSP outside slot writes 180.
// - Rewriting loop control in the last three loop instructions writes 180.
// - Same faults in a delay slot save branch address and write 1A0.
// - Break saves next or own address by break kind, writes 1E0.
// - Misaligned DMA word or long saves next address and status, writes 5C0.
// - General exceptions save PC and status, set mode flags, base plus 100; a TLB miss outside loop end goes to base plus 400.
// - General exception other than break, with hold flag set, resets CPU and branches to reset.
// - Event code register holds a 12-bit code written on each event.
`timescale 1ns/1ns
`include "raed_defs.svh"

module raed_top (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // Reset sources
    input wire logic POWER_ON_RESET_PIN_N,
    input wire logic MANUAL_RESET_PIN_N,
    input wire logic DEBUG_RESET_CMD,
    // Program counters of the instruction at the boundary
    input wire logic [31:0] CUR_PC,
    input wire logic [31:0] NEXT_PC,
    input wire logic [31:0] BRANCH_PC,
    input wire logic IN_DELAY_SLOT,
    input wire logic LOOP_END_ZONE,
    input wire logic LOOP_LAST_THREE,
    // CPU memory access and TLB lookup
    input wire logic MEM_VALID,
    input wire logic MEM_WRITE,
    input wire logic MEM_FETCH,
    input wire logic [1:0] MEM_SIZE,
    input wire logic [31:0] MEM_ADDR,
    input wire logic TLB_HIT,
    input wire logic TLB_VALID,
    input wire logic TLB_DIRTY,
    input wire logic [1:0] ACCESS_RIGHTS_CODE,
    input wire logic [1:0] TLB_WAY,
    input wire logic [7:0] ADDRESS_SPACE_ID,
    // Decode stage
    input wire logic DEC_VALID,
    input wire logic DEC_UNDEFINED,
    input wire logic DEC_PRIVILEGED,
    input wire logic DEC_DSP,
    input wire logic DEC_WRITES_PC,
    input wire logic DEC_WRITES_STATUS,
    input wire logic DEC_WRITES_LOOP,
    input wire logic DEC_TRAP,
    input wire logic [7:0] DEC_TRAP_IMM,
    // Break controller and DMA controller
    input wire logic BREAK_REQ,
    input wire logic BREAK_POST,
    input wire logic DMA_REQ,
    input wire logic [1:0] DMA_SIZE,
    input wire logic [31:0] DMA_ADDR,
    // Software loads
    input wire logic STATUS_LOAD,
    input wire logic [31:0] STATUS_WDATA,
    input wire logic VECTOR_BASE_LOAD,
    input wire logic [31:0] VECTOR_BASE_WDATA,
    input wire logic EVENT_CODE_LOAD,
    input wire logic [11:0] EVENT_CODE_WDATA,
    // Recorded state
    output logic [11:0] EXCEPTION_EVENT_CODE,
    output logic [31:0] VECTOR_BASE,
    output logic [31:0] STATUS_WORD,
    output logic [31:0] SAVED_PROGRAM_COUNTER,
    output logic [31:0] SAVED_STATUS_WORD,
    output logic [31:0] FAULTING_ADDRESS,
    output logic [31:0] PAGE_TABLE_ENTRY_HIGH,
    output logic [31:0] MMU_CONTROL,
    output logic [31:0] TRAP_OPERAND_COPY,
    // Fetch redirect and reset fan-out
    output logic FETCH_REDIRECT,
    output logic [31:0] FETCH_TARGET,
    output logic CPU_REG_RESET,
    output logic MODULE_RESET
);
    raed_pkg::raed_event_e next_ev;
    logic [11:0] next_code;
    logic [31:0] next_save_pc;
    logic [31:0] next_vec;
    logic por_low;
    logic man_low;
    logic rst_any;
    logic user;
    logic hold;
    logic dsp_on;
    logic addr_fault;
    logic rights_fault;
    logic mem_fault;
    logic dec_fault;
    logic trap_take;
    logic tlb_fault;
    logic mem_ev;
    logic way_inc;
    logic way_load;
    logic gen;

    assign por_low = !POWER_ON_RESET_PIN_N;
    assign man_low = !MANUAL_RESET_PIN_N;
    assign rst_any = por_low || man_low || DEBUG_RESET_CMD;
    assign user = !STATUS_WORD[`RAED_SW_PRIV];
    assign hold = STATUS_WORD[`RAED_SW_HOLD];
    assign dsp_on = STATUS_WORD[`RAED_SW_DSP];

    raed_access_check u_check (
        .addr(MEM_ADDR),
        .size(MEM_SIZE),
        .fetch(MEM_FETCH),
        .write(MEM_WRITE),
        .user(user),
        .rights(ACCESS_RIGHTS_CODE),
        .addr_fault(addr_fault),
        .rights_fault(rights_fault)
    );

    // Address errors are checked before any TLB outcome
    assign mem_fault = MEM_VALID && (addr_fault || !TLB_HIT || !TLB_VALID || rights_fault
                       || (MEM_WRITE && !TLB_DIRTY));

    // Decode faults; in a slot PC writers are illegal, outside it loop writers near the end
    always_comb begin
        if (IN_DELAY_SLOT) begin
            dec_fault = DEC_UNDEFINED || DEC_WRITES_PC || (DEC_PRIVILEGED && user)
                        || (DEC_DSP && !dsp_on);
        end else begin
            dec_fault = DEC_UNDEFINED || (DEC_PRIVILEGED && user) || (DEC_DSP && !dsp_on)
                        || (LOOP_LAST_THREE && (DEC_WRITES_PC || DEC_WRITES_STATUS
                        || DEC_WRITES_LOOP));
        end
    end

    // Event selection: resets, then access faults, decode, break, DMA
    always_comb begin
        next_ev = raed_pkg::RAED_EV_NONE;
        next_code = `RAED_CODE_POWER_ON;
        next_save_pc = CUR_PC;
        next_vec = `RAED_VEC_GEN;
        trap_take = 1'b0;
        tlb_fault = 1'b0;
        mem_ev = 1'b0;
        way_inc = 1'b0;
        way_load = 1'b0;
        if (rst_any) begin
            next_ev = raed_pkg::RAED_EV_RESET;
            if (por_low || DEBUG_RESET_CMD) begin
                next_code = `RAED_CODE_POWER_ON;
            end else begin
                next_code = `RAED_CODE_MANUAL;
            end
        end else if (mem_fault) begin
            next_ev = raed_pkg::RAED_EV_GENERAL;
            mem_ev = 1'b1;
            if (addr_fault) begin
                next_code = MEM_WRITE ? `RAED_CODE_ADDR_WR : `RAED_CODE_ADDR_RD;
            end else if (!TLB_HIT) begin
                tlb_fault = 1'b1;
                way_inc = 1'b1;
                next_code = MEM_WRITE ? `RAED_CODE_TLB_WR : `RAED_CODE_TLB_RD;
                next_vec = `RAED_VEC_MISS;
            end else if (!TLB_VALID) begin
                tlb_fault = 1'b1;
                way_load = 1'b1;
                next_code = MEM_WRITE ? `RAED_CODE_TLB_WR : `RAED_CODE_TLB_RD;
            end else if (rights_fault) begin
                tlb_fault = 1'b1;
                way_load = 1'b1;
                next_code = MEM_WRITE ? `RAED_CODE_PROT_WR : `RAED_CODE_PROT_RD;
            end else begin
                tlb_fault = 1'b1;
                way_load = 1'b1;
                next_code = `RAED_CODE_INIT_WR;
            end
            // At loop end the loop cannot resume, so the next address is saved instead of the current PC
            if (LOOP_END_ZONE && next_code != `RAED_CODE_INIT_WR) begin
                next_code = `RAED_CODE_LOOP;
                next_vec = `RAED_VEC_GEN;
                next_save_pc = NEXT_PC;
            end
        end else if (DEC_VALID && dec_fault) begin
            next_ev = raed_pkg::RAED_EV_GENERAL;
            if (IN_DELAY_SLOT) begin
                next_code = `RAED_CODE_SLOT;
                next_save_pc = BRANCH_PC;
            end else begin
                next_code = `RAED_CODE_RESV;
            end
        end else if (DEC_VALID && DEC_TRAP) begin
            next_ev = raed_pkg::RAED_EV_GENERAL;
            trap_take = 1'b1;
            next_code = `RAED_CODE_TRAP;
            next_save_pc = NEXT_PC;
        end else if (BREAK_REQ && !hold) begin
            next_ev = raed_pkg::RAED_EV_GENERAL;
            next_code = `RAED_CODE_BREAK;
            next_save_pc = BREAK_POST ? NEXT_PC : CUR_PC;
        end else if (DMA_REQ && raed_pkg::raed_misaligned(DMA_ADDR[1:0], DMA_SIZE)) begin
            next_ev = raed_pkg::RAED_EV_GENERAL;
            next_code = `RAED_CODE_DMA;
            next_save_pc = NEXT_PC;
        end
        if (next_ev == raed_pkg::RAED_EV_GENERAL && hold) begin
            next_ev = raed_pkg::RAED_EV_DOUBLE;
        end
    end

    assign gen = (next_ev == raed_pkg::RAED_EV_GENERAL);

    // Event code; hardware events win over a software load
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            EXCEPTION_EVENT_CODE <= `RAED_CODE_POWER_ON;
        end else if (next_ev != raed_pkg::RAED_EV_NONE) begin
            EXCEPTION_EVENT_CODE <= next_code;
        end else if (EVENT_CODE_LOAD) begin
            EXCEPTION_EVENT_CODE <= EVENT_CODE_WDATA;
        end
    end

    // Vector base and status word
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            VECTOR_BASE <= `RAED_VECTOR_BASE_RESET;
            STATUS_WORD <= `RAED_SW_RESET;
        end else begin
            unique case (next_ev)
                raed_pkg::RAED_EV_RESET, raed_pkg::RAED_EV_DOUBLE: begin
                    VECTOR_BASE <= `RAED_VECTOR_BASE_RESET;
                    STATUS_WORD <= `RAED_SW_RESET;
                end
                raed_pkg::RAED_EV_GENERAL: begin
                    STATUS_WORD <= STATUS_WORD | `RAED_SW_MODE_SET;
                end
                raed_pkg::RAED_EV_NONE: begin
                    if (VECTOR_BASE_LOAD) begin
                        VECTOR_BASE <= VECTOR_BASE_WDATA;
                    end
                    if (STATUS_LOAD) begin
                        STATUS_WORD <= STATUS_WDATA;
                    end
                end
            endcase
        end
    end

    // Saved context
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            SAVED_PROGRAM_COUNTER <= 32'h00000000;
            SAVED_STATUS_WORD <= 32'h00000000;
        end else if (gen) begin
            SAVED_PROGRAM_COUNTER <= next_save_pc;
            SAVED_STATUS_WORD <= STATUS_WORD;
        end
    end

    // Fault address, page number and space id
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            FAULTING_ADDRESS <= 32'h00000000;
            PAGE_TABLE_ENTRY_HIGH <= 32'h00000000;
        end else if (gen && mem_ev) begin
            FAULTING_ADDRESS <= MEM_ADDR;
            if (tlb_fault) begin
                PAGE_TABLE_ENTRY_HIGH <= {MEM_ADDR[31:`RAED_PAGE_VPN_LO],
                    PAGE_TABLE_ENTRY_HIGH[`RAED_PAGE_VPN_LO-1:`RAED_PAGE_ID_HI+1],
                    ADDRESS_SPACE_ID};
            end
        end
    end

    // Replacement way field
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            MMU_CONTROL <= 32'h00000000;
        end else if (gen && way_inc) begin
            MMU_CONTROL[`RAED_WAY_HI:`RAED_WAY_LO] <=
                MMU_CONTROL[`RAED_WAY_HI:`RAED_WAY_LO] + 2'h1;
        end else if (gen && way_load) begin
            MMU_CONTROL[`RAED_WAY_HI:`RAED_WAY_LO] <= TLB_WAY;
        end
    end

    // Trap operand, immediate times four
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            TRAP_OPERAND_COPY <= 32'h00000000;
        end else if (gen && trap_take) begin
            TRAP_OPERAND_COPY <= {22'h000000, DEC_TRAP_IMM, 2'h0};
        end
    end

    // Fetch redirect and reset fan-out
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            FETCH_REDIRECT <= 1'b0;
            FETCH_TARGET <= `RAED_RESET_PC;
            CPU_REG_RESET <= 1'b0;
            MODULE_RESET <= 1'b0;
        end else begin
            FETCH_REDIRECT <= (next_ev != raed_pkg::RAED_EV_NONE);
            CPU_REG_RESET <= (next_ev == raed_pkg::RAED_EV_RESET)
                             || (next_ev == raed_pkg::RAED_EV_DOUBLE);
            MODULE_RESET <= (next_ev == raed_pkg::RAED_EV_RESET);
            if (gen) begin
                FETCH_TARGET <= VECTOR_BASE + next_vec;
            end else if (next_ev != raed_pkg::RAED_EV_NONE) begin
                FETCH_TARGET <= `RAED_RESET_PC;
            end
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    sequence s_por_req;
        por_low || DEBUG_RESET_CMD;
    endsequence
    sequence s_reset_done(logic [11:0] code);
        FETCH_REDIRECT && FETCH_TARGET == `RAED_RESET_PC && EXCEPTION_EVENT_CODE == code;
    endsequence
    sequence s_gen_done;
        FETCH_REDIRECT && STATUS_WORD[30:28] == 3'h7;
    endsequence

    property p_por;
        s_por_req |=> s_reset_done(`RAED_CODE_POWER_ON);
    endproperty
    a_por: assert property (p_por) else $error("power-on reset sequence wrong");

    property p_manual;
        (man_low && !por_low && !DEBUG_RESET_CMD) |=> s_reset_done(`RAED_CODE_MANUAL);
    endproperty
    a_manual: assert property (p_manual) else $error("manual reset sequence wrong");

    property p_reset_flags;
        rst_any |=> VECTOR_BASE == 32'h0 && STATUS_WORD[30:28] == 3'h7
            && STATUS_WORD[`RAED_SW_MASK_HI:`RAED_SW_MASK_LO] == `RAED_MASK_RESET;
    endproperty
    a_reset_flags: assert property (p_reset_flags) else $error("reset flags wrong");

    property p_debug;
        DEBUG_RESET_CMD |=> MODULE_RESET && CPU_REG_RESET && EXCEPTION_EVENT_CODE == 12'h000;
    endproperty
    a_debug: assert property (p_debug) else $error("debug reset not power-on");

    property p_fault_addr;
        (gen && tlb_fault) |=> FAULTING_ADDRESS == $past(MEM_ADDR)
            && PAGE_TABLE_ENTRY_HIGH[7:0] == $past(ADDRESS_SPACE_ID)
            && PAGE_TABLE_ENTRY_HIGH[31:10] == $past(MEM_ADDR[31:10]);
    endproperty
    a_fault_addr: assert property (p_fault_addr) else $error("fault address lost");

    property p_way_inc;
        (gen && way_inc) |=> MMU_CONTROL[7:6] == $past(MMU_CONTROL[7:6]) + 2'h1;
    endproperty
    a_way_inc: assert property (p_way_inc) else $error("way not advanced");

    property p_miss_vec;
        (gen && way_inc && !LOOP_END_ZONE) |=> s_gen_done
            ##0 FETCH_TARGET == $past(VECTOR_BASE) + 32'h400;
    endproperty
    a_miss_vec: assert property (p_miss_vec) else $error("miss vector wrong");

    property p_loop;
        (gen && mem_ev && LOOP_END_ZONE && !(TLB_HIT && TLB_VALID && !rights_fault && !addr_fault))
            |=> EXCEPTION_EVENT_CODE == 12'h070 && SAVED_PROGRAM_COUNTER == $past(NEXT_PC);
    endproperty
    a_loop: assert property (p_loop) else $error("loop fault code wrong");

    property p_trap;
        (gen && trap_take) |=> TRAP_OPERAND_COPY[9:0] == {$past(DEC_TRAP_IMM), 2'h0}
            && EXCEPTION_EVENT_CODE == 12'h160 && SAVED_PROGRAM_COUNTER == $past(NEXT_PC);
    endproperty
    a_trap: assert property (p_trap) else $error("trap operand wrong");

    property p_slot;
        (gen && DEC_VALID && IN_DELAY_SLOT && dec_fault && !mem_fault) |=>
            EXCEPTION_EVENT_CODE == 12'h1A0 && SAVED_PROGRAM_COUNTER == $past(BRANCH_PC);
    endproperty
    a_slot: assert property (p_slot) else $error("illegal slot handling wrong");

    property p_general;
        gen |=> s_gen_done ##0 SAVED_STATUS_WORD == $past(STATUS_WORD);
    endproperty
    a_general: assert property (p_general) else $error("context not saved");

    property p_double;
        (next_ev == raed_pkg::RAED_EV_DOUBLE) |=> CPU_REG_RESET && !MODULE_RESET
            && FETCH_TARGET == `RAED_RESET_PC && VECTOR_BASE == 32'h0;
    endproperty
    a_double: assert property (p_double) else $error("double fault handling wrong");
endmodule

/* testbench/raed_mmu_model.sv */
// Model of the pipeline memory stage and the MMU lookup feeding the unit.
// Assumes requests are issued just after a rising edge of MCLK.
`timescale 1ns/1ns
module raed_mmu_model (
    // Access
    output logic MEM_VALID,
    output logic MEM_WRITE,
    output logic MEM_FETCH,
    output logic [1:0] MEM_SIZE,
    output logic [31:0] MEM_ADDR,
    // Lookup result
    output logic TLB_HIT,
    output logic TLB_VALID,
    output logic TLB_DIRTY,
    output logic [1:0] ACCESS_RIGHTS_CODE,
    output logic [1:0] TLB_WAY
);
    initial begin
        {MEM_VALID, MEM_WRITE, MEM_FETCH, MEM_SIZE, MEM_ADDR} = '0;
        {TLB_HIT, TLB_VALID, TLB_DIRTY, ACCESS_RIGHTS_CODE, TLB_WAY} = '0;
    end
    // Kind is write, fetch, size; lookup is hit, valid, dirty, rights
    task automatic req(input logic [3:0] k, input logic [31:0] a, input logic [4:0] t,
                       input logic [1:0] w);
        {MEM_WRITE, MEM_FETCH, MEM_SIZE} <= k;
        MEM_ADDR <= a;
        {TLB_HIT, TLB_VALID, TLB_DIRTY, ACCESS_RIGHTS_CODE} <= t;
        TLB_WAY <= w;
        MEM_VALID <= 1'h1;
    endtask
    // Released lines no longer show the last value
    task automatic rel;
        MEM_VALID <= 1'h0;
        MEM_ADDR <= ~MEM_ADDR;
        {TLB_HIT, TLB_VALID, TLB_DIRTY} <= ~{TLB_HIT, TLB_VALID, TLB_DIRTY};
    endtask
endmodule

/* testbench/test_reset_and_exception_dispatch.sv */
// Self-checking bench for the reset and exception dispatch unit.
// Assumes each event is answered at the edge that takes it.
`timescale 1ns/1ns
module test_reset_and_exception_dispatch;
    localparam logic [31:0] CU = 32'h00001230, NX = 32'h00001232, BR = 32'h0000122C;
    logic MCLK, RST, POWER_ON_RESET_PIN_N, MANUAL_RESET_PIN_N, DEBUG_RESET_CMD;
    logic IN_DELAY_SLOT, LOOP_END_ZONE, LOOP_LAST_THREE, DEC_VALID, DEC_UNDEFINED;
    logic DEC_PRIVILEGED, DEC_DSP, DEC_WRITES_PC, DEC_WRITES_STATUS, DEC_WRITES_LOOP;
    logic DEC_TRAP, BREAK_REQ, BREAK_POST, DMA_REQ, STATUS_LOAD, VECTOR_BASE_LOAD;
    logic EVENT_CODE_LOAD, MEM_VALID, MEM_WRITE, MEM_FETCH, TLB_HIT, TLB_VALID, TLB_DIRTY;
    logic FETCH_REDIRECT, CPU_REG_RESET, MODULE_RESET;
    logic [1:0] MEM_SIZE, ACCESS_RIGHTS_CODE, TLB_WAY, DMA_SIZE;
    logic [7:0] ADDRESS_SPACE_ID, DEC_TRAP_IMM;
    logic [11:0] EVENT_CODE_WDATA, EXCEPTION_EVENT_CODE, dec;
    logic [31:0] CUR_PC, NEXT_PC, BRANCH_PC, MEM_ADDR, DMA_ADDR, STATUS_WDATA;
    logic [31:0] VECTOR_BASE_WDATA, VECTOR_BASE, STATUS_WORD, SAVED_PROGRAM_COUNTER;
    logic [31:0] SAVED_STATUS_WORD, FAULTING_ADDRESS, PAGE_TABLE_ENTRY_HIGH, MMU_CONTROL;
    logic [31:0] TRAP_OPERAND_COPY, FETCH_TARGET, st;
    int error_cnt = 0, tests_run = 0;
    logic [11:0] fl [8] = '{12'h8A0, 12'hA00, 12'h900, 12'h848, 12'hC10, 12'h006, 12'h004,
                           12'h001};
    logic [11:0] cd [8] = '{12'h160, 12'h180, 12'h180, 12'h180, 12'h1A0, 12'h1E0, 12'h1E0,
                           12'h5C0};
    logic [31:0] pv [8] = '{NX, CU, CU, CU, BR, NX, CU, NX};
    assign {DEC_VALID, DEC_UNDEFINED, DEC_PRIVILEGED, DEC_DSP, DEC_WRITES_PC, DEC_WRITES_LOOP,
            DEC_TRAP, IN_DELAY_SLOT, LOOP_LAST_THREE, BREAK_REQ, BREAK_POST, DMA_REQ} = dec;
    raed_top dut (.*);
    raed_mmu_model pm (.*);
    always #10 MCLK = ~MCLK;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic arm(input logic [31:0] s);
        @(posedge MCLK);
        {STATUS_LOAD, VECTOR_BASE_LOAD, EVENT_CODE_LOAD} <= 3'h7;
        STATUS_WDATA <= s;
        st = s;
        @(posedge MCLK);
        {STATUS_LOAD, VECTOR_BASE_LOAD, EVENT_CODE_LOAD} <= 3'h0;
    endtask
    task automatic fire;
        @(posedge MCLK);
        dec <= 12'h000;
        {POWER_ON_RESET_PIN_N, MANUAL_RESET_PIN_N, DEBUG_RESET_CMD, LOOP_END_ZONE,
         DEC_WRITES_STATUS} <= 5'h18;
        pm.rel();
        #1;
    endtask
    task automatic ev(input logic [11:0] c, input logic [31:0] t, input logic [31:0] pc);
        chk("redirect", 32'h1, FETCH_REDIRECT);
        chk("code", c, EXCEPTION_EVENT_CODE);
        chk("target", t, FETCH_TARGET);
        chk("saved pc", pc, SAVED_PROGRAM_COUNTER);
        chk("saved status", st, SAVED_STATUS_WORD);
        chk("mode flags", 32'h7, STATUS_WORD[30:28]);
    endtask
    task automatic rs(input logic [11:0] c);
        chk("redirect", 32'h1, FETCH_REDIRECT);
        chk("code", c, EXCEPTION_EVENT_CODE);
        chk("target", 32'hA0000000, FETCH_TARGET);
        chk("base", 32'h0, VECTOR_BASE);
        chk("status", 32'h7F, {STATUS_WORD[30:28], STATUS_WORD[7:4]});
        chk("cpu reset", 32'h1, CPU_REG_RESET);
    endtask
    task automatic stop_test;
        $display("Checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge MCLK);
        error_cnt++;
        stop_test();
    end
    initial begin
        {MCLK, RST, dec, DEC_WRITES_STATUS, DEBUG_RESET_CMD, LOOP_END_ZONE} = 17'h08000;
        {POWER_ON_RESET_PIN_N, MANUAL_RESET_PIN_N, STATUS_LOAD} = 3'h6;
        {VECTOR_BASE_LOAD, EVENT_CODE_LOAD, STATUS_WDATA} = '0;
        {CUR_PC, NEXT_PC, BRANCH_PC} = {CU, NX, BR};
        {ADDRESS_SPACE_ID, DEC_TRAP_IMM, EVENT_CODE_WDATA} = 28'h5AFF3C0;
        {DMA_SIZE, DMA_ADDR, VECTOR_BASE_WDATA} = {2'h2, 32'h00402002, 32'h00008000};
        repeat (20) @(posedge MCLK);
        RST <= 1'h0;
        @(posedge MCLK);
        #1;
        chk("reset code", 32'h0, EXCEPTION_EVENT_CODE);
        chk("reset target", 32'hA0000000, FETCH_TARGET);
        arm(32'h0);
        POWER_ON_RESET_PIN_N <= 1'h0;
        fire();
        rs(12'h000);
        chk("module reset", 32'h1, MODULE_RESET);
        arm(32'h0);
        MANUAL_RESET_PIN_N <= 1'h0;
        fire();
        rs(12'h020);
        arm(32'h0);
        DEBUG_RESET_CMD <= 1'h1;
        fire();
        rs(12'h000);
        chk("module reset", 32'h1, MODULE_RESET);
        arm(32'h0);
        pm.req(4'hA, 32'h00401238, 5'h17, 2'h2);
        fire();
        ev(12'h060, 32'h00008100, CU);
        chk("way", 32'h2, MMU_CONTROL[7:6]);
        arm(32'h0);
        pm.req(4'h2, 32'h12345670, 5'h00, 2'h0);
        fire();
        ev(12'h040, 32'h00008400, CU);
        chk("fault addr", 32'h12345670, FAULTING_ADDRESS);
        chk("page", {22'h048D15, 8'h5A}, {PAGE_TABLE_ENTRY_HIGH[31:10],
            PAGE_TABLE_ENTRY_HIGH[7:0]});
        chk("way", 32'h3, MMU_CONTROL[7:6]);
        arm(32'h0);
        pm.req(4'h2, 32'h00402000, 5'h1C, 2'h1);
        fire();
        ev(12'h0A0, 32'h00008100, CU);
        chk("way", 32'h1, MMU_CONTROL[7:6]);
        arm(32'h40000000);
        pm.req(4'hA, 32'h00402000, 5'h1C, 2'h1);
        fire();
        ev(12'h0C0, 32'h00008100, CU);
        arm(32'h40000000);
        pm.req(4'hA, 32'h00402000, 5'h1D, 2'h1);
        fire();
        chk("no redirect", 32'h0, FETCH_REDIRECT);
        arm(32'h40000000);
        pm.req(4'hA, 32'h00402000, 5'h1B, 2'h0);
        fire();
        ev(12'h080, 32'h00008100, CU);
        chk("way", 32'h0, MMU_CONTROL[7:6]);
        arm(32'h40000000);
        pm.req(4'hA, 32'h00402002, 5'h1F, 2'h1);
        fire();
        ev(12'h100, 32'h00008100, CU);
        chk("fault addr", 32'h00402002, FAULTING_ADDRESS);
        arm(32'h0);
        pm.req(4'h0, 32'h80000000, 5'h1F, 2'h1);
        fire();
        ev(12'h0E0, 32'h00008100, CU);
        arm(32'h0);
        pm.req(4'h4, 32'h00402001, 5'h1F, 2'h1);
        fire();
        ev(12'h0E0, 32'h00008100, CU);
        arm(32'h0);
        LOOP_END_ZONE <= 1'h1;
        pm.req(4'h2, 32'h00403000, 5'h00, 2'h0);
        fire();
        ev(12'h070, 32'h00008100, NX);
        arm(32'h0);
        DEC_WRITES_STATUS <= 1'h1;
        dec <= 12'h808;
        fire();
        ev(12'h180, 32'h00008100, CU);
        for (int i = 0; i < 8; i++) begin
            arm(32'h0);
            dec <= fl[i];
            fire();
            ev(cd[i], 32'h00008100, pv[i]);
            if (i == 0) begin
                chk("trap copy", 32'h3FC, TRAP_OPERAND_COPY[9:0]);
            end
        end
        arm(32'h10000000);
        dec <= 12'h004;
        fire();
        chk("no redirect", 32'h0, FETCH_REDIRECT);
        arm(32'h10000000);
        dec <= 12'hC00;
        fire();
        rs(12'h180);
        chk("module reset", 32'h0, MODULE_RESET);
        chk("saved pc kept", NX, SAVED_PROGRAM_COUNTER);
        stop_test();
    end
endmodule
